// ==== verilog/mgmt_link_defs.svh ====
// Timing constants and the contract for the two-wire management link.
// Contract
// - Deselect mid-sequence releases SCL and SDA within 2 ms.
// - Host asserts select 2 ms before a sequence.
// - Select may change 500 us after sequence end.
// - Module supports setup and hold without extension.
// - Module exposes its setup and hold times readably.
// - SCL rate default 400 kHz, 1 MHz optional.
// - Read clock stretch totals at most 500 us.
// - Volatile write hold-off ends within 10 ms.
// - Non-volatile write hold-off ends within 80 ms.
// - Host leaves bus idle 20 us between transactions.
// - Write interval runs from STOP to next START.
// - Busy module NACKs the control byte.
// - Stretch starts only while SCL is already low.
// - Host polls readiness with a dummy write.
`ifndef MGMT_LINK_DEFS_SVH
`define MGMT_LINK_DEFS_SVH
`define SYS_CLK_MHZ              50
`define DESELECT_ABORT_MS        2
`define SELECT_SETUP_MS          2
`define SELECT_HOLD_US           500
`define READ_STRETCH_LIMIT_US    500
`define VOLATILE_HOLDOFF_MS      10
`define NONVOLATILE_HOLDOFF_MS   80
`define BUS_FREE_US              20
`define SCL_DEFAULT_KHZ          400
`define SCL_FAST_KHZ             1000
`define SELECT_SETUP_CYC         (`SELECT_SETUP_MS * 1000 * `SYS_CLK_MHZ)
`define BUS_FREE_CYC             (`BUS_FREE_US * `SYS_CLK_MHZ)
`define READ_STRETCH_CYC         (`READ_STRETCH_LIMIT_US * `SYS_CLK_MHZ)
`define VOLATILE_HOLDOFF_CYC     (`VOLATILE_HOLDOFF_MS * 1000 * `SYS_CLK_MHZ)
`define NONVOLATILE_HOLDOFF_CYC  (`NONVOLATILE_HOLDOFF_MS * 1000 * `SYS_CLK_MHZ)
`define SCL_HALF_DEFAULT_CYC     ((`SYS_CLK_MHZ * 1000 + 2 * `SCL_DEFAULT_KHZ - 1) / (2 * `SCL_DEFAULT_KHZ))
`define SCL_HALF_FAST_CYC        ((`SYS_CLK_MHZ * 1000 + 2 * `SCL_FAST_KHZ - 1) / (2 * `SCL_FAST_KHZ))
`define DEV_ADDR                 7'h50
`define ADVERTISED_SETUP         8'h02
`define ADVERTISED_HOLD          8'h32
`define DEV_WAIT_BYTE            8'ha5
`define ADV_SETUP_ADDR           8'hfe
`define ADV_HOLD_ADDR            8'hff
`endif

// ==== verilog/mgmt_link_pkg.sv ====
// Types shared by both ends of the management link.
package mgmt_link_pkg;
  typedef enum logic [1:0] {WR_VOLATILE, WR_NONVOLATILE, WR_NONE} write_kind_t;
  typedef logic [7:0] byte_t;
endpackage

// ==== verilog/mgmt_link_if.sv ====
// Interface joining the host and module ends of the two-wire link.
`timescale 1ns/1ps
`default_nettype none
interface mgmt_link_if;
  logic scl_h_oe;
  logic sda_h_oe;
  logic scl_m_oe;
  logic sda_m_oe;
  logic module_select_n;
  wire  scl = ~(scl_h_oe | scl_m_oe);
  wire  sda = ~(sda_h_oe | sda_m_oe);
  modport host (output scl_h_oe, output sda_h_oe, output module_select_n, input scl, input sda);
  modport dev (output scl_m_oe, output sda_m_oe, input module_select_n, input scl, input sda);
endinterface
`default_nettype wire

// ==== verilog/mgmt_link_dev.sv ====
// Module end: two-wire target with select abort, stretch and write hold-off.
`timescale 1ns/1ps
`default_nettype none
`include "mgmt_link_defs.svh"
module mgmt_link_dev #(
  parameter int NV_CYC  = `NONVOLATILE_HOLDOFF_CYC,
  parameter int VOL_CYC = `VOLATILE_HOLDOFF_CYC,
  parameter int RD_CYC  = `READ_STRETCH_CYC
) (
  input  wire logic                 SYS_CLK,
  input  wire logic                 RST_N,
  mgmt_link_if.dev                  LINK,
  input  wire logic                 NV_TARGET,
  input  wire logic                 RD_DATA_VALID,
  input  wire mgmt_link_pkg::byte_t RD_DATA,
  output logic                      WR_STROBE,
  output mgmt_link_pkg::byte_t      WR_ADDR,
  output mgmt_link_pkg::byte_t      WR_DATA,
  output logic                      BUSY
);
  import mgmt_link_pkg::*;
  typedef enum {S_IDLE, S_BITS, S_ACK, S_TXBITS, S_RXACK, S_STRETCH, S_IGNORE} dstate_t;
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [1:0] sel_sync_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;
  logic       scl_s;
  logic       sda_s;
  logic       sel_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_ev;
  logic       stop_ev;
  dstate_t    state_reg;
  logic [3:0] bit_cnt_reg;
  byte_t      shift_reg;
  logic [1:0] byte_idx_reg;
  logic       read_reg;
  logic       nack_reg;
  byte_t      addr_reg;
  byte_t      data_reg;
  logic       wr_pend_reg;
  logic [31:0] hold_cnt_reg;
  logic [31:0] str_cnt_reg;
  logic       sda_oe_reg;
  logic       scl_oe_reg;
  byte_t      tx_reg;
  logic       adv_hit;
  byte_t      tx_first;

  // Two-flop synchronisers on all inputs from the link.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      sel_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], LINK.scl};
      sda_sync_reg <= {sda_sync_reg[0], LINK.sda};
      sel_sync_reg <= {sel_sync_reg[0], LINK.module_select_n};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end

  // Edge and bus condition detection on synchronised lines.
  assign scl_s    = scl_sync_reg[1];
  assign sda_s    = sda_sync_reg[1];
  assign sel_s    = ~sel_sync_reg[1];
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // The current address picks the advertised select timings or the external read byte.
  assign adv_hit  = (addr_reg == `ADV_SETUP_ADDR) || (addr_reg == `ADV_HOLD_ADDR);
  assign tx_first = adv_hit ? ((addr_reg == `ADV_SETUP_ADDR) ? `ADVERTISED_SETUP : `ADVERTISED_HOLD)
                            : (RD_DATA_VALID ? RD_DATA : `DEV_WAIT_BYTE);

  // Hold-off timer started at the STOP of each write that delivered a data byte.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      hold_cnt_reg <= 32'h0;
    end else if (stop_ev && wr_pend_reg) begin
      hold_cnt_reg <= NV_TARGET ? 32'(NV_CYC / 2) : 32'(VOL_CYC / 2);
    end else if (hold_cnt_reg != 32'h0) begin
      hold_cnt_reg <= hold_cnt_reg - 32'h1;
    end
  end
  assign BUSY = (hold_cnt_reg != 32'h0);

  // Commit the buffered byte on a proper STOP.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      WR_STROBE <= 1'b0;
      WR_ADDR   <= 8'h00;
      WR_DATA   <= 8'h00;
    end else begin
      WR_STROBE <= stop_ev & wr_pend_reg;
      if (stop_ev && wr_pend_reg) begin
        WR_ADDR <= addr_reg;
        WR_DATA <= data_reg;
      end
    end
  end

  // Target protocol engine.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || !sel_s) begin
      state_reg    <= S_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      byte_idx_reg <= 2'h0;
      read_reg     <= 1'b0;
      nack_reg     <= 1'b0;
      addr_reg     <= 8'h00;
      data_reg     <= 8'h00;
      wr_pend_reg  <= 1'b0;
      sda_oe_reg   <= 1'b0;
      scl_oe_reg   <= 1'b0;
      str_cnt_reg  <= 32'h0;
      tx_reg       <= 8'h00;
    end else if (start_ev) begin
      state_reg    <= S_BITS;
      bit_cnt_reg  <= 4'h0;
      byte_idx_reg <= 2'h0;
      wr_pend_reg  <= 1'b0;
      sda_oe_reg   <= 1'b0;
      str_cnt_reg  <= 32'h0;
    end else if (stop_ev) begin
      state_reg   <= S_IDLE;
      sda_oe_reg  <= 1'b0;
      wr_pend_reg <= 1'b0;
    end else begin
      case (state_reg)
        S_BITS: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            bit_cnt_reg <= 4'h0;
            state_reg   <= S_ACK;
            if (byte_idx_reg == 2'h0) begin
              nack_reg   <= BUSY || (shift_reg[7:1] != `DEV_ADDR);
              sda_oe_reg <= !(BUSY || (shift_reg[7:1] != `DEV_ADDR));
              read_reg   <= shift_reg[0];
            end else begin
              nack_reg   <= 1'b0;
              sda_oe_reg <= 1'b1;
              if (byte_idx_reg == 2'h1) begin
                addr_reg <= shift_reg;
              end else begin
                data_reg    <= shift_reg;
                wr_pend_reg <= 1'b1;
              end
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            if (nack_reg) begin
              state_reg <= S_IGNORE;
            end else if (read_reg && byte_idx_reg == 2'h0) begin
              scl_oe_reg  <= 1'b1;
              str_cnt_reg <= 32'h0;
              state_reg   <= S_STRETCH;
            end else begin
              byte_idx_reg <= (byte_idx_reg == 2'h2) ? 2'h2 : byte_idx_reg + 2'h1;
              state_reg    <= S_BITS;
            end
          end
        end
        S_STRETCH: begin
          str_cnt_reg <= str_cnt_reg + 32'h1;
          if (adv_hit || RD_DATA_VALID || str_cnt_reg >= 32'(RD_CYC - 2)) begin
            tx_reg      <= tx_first;
            sda_oe_reg  <= ~tx_first[7];
            scl_oe_reg  <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg   <= S_TXBITS;
          end
        end
        S_TXBITS: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h7) begin
              sda_oe_reg <= 1'b0;
              state_reg  <= S_RXACK;
            end else begin
              sda_oe_reg <= ~tx_reg[6];
              tx_reg     <= {tx_reg[6:0], 1'b0};
            end
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
        S_RXACK: begin
          if (scl_rise) begin
            state_reg <= sda_s ? S_IGNORE : S_STRETCH;
          end
        end
        S_IGNORE: begin
          sda_oe_reg <= 1'b0;
        end
        default: begin
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // Pins are released as soon as the synchronised select drops; no extra setup is needed.
  assign LINK.scl_m_oe = scl_oe_reg & sel_s;
  assign LINK.sda_m_oe = sda_oe_reg & sel_s;
endmodule // mgmt_link_dev
`default_nettype wire

// ==== verilog/mgmt_link_host.sv ====
// Host end: two-wire initiator with select setup and bus-free gap.
`timescale 1ns/1ps
`default_nettype none
`include "mgmt_link_defs.svh"
module mgmt_link_host #(
  parameter int SETUP_CYC = `SELECT_SETUP_CYC
) (
  input  wire logic                 SYS_CLK,
  input  wire logic                 RST_N,
  mgmt_link_if.host                 LINK,
  input  wire logic                 FAST_MODE,
  input  wire logic                 SELECT,
  input  wire logic                 REQ_VALID,
  input  wire logic                 REQ_READ,
  input  wire logic                 REQ_POLL,
  input  wire mgmt_link_pkg::byte_t REQ_ADDR,
  input  wire mgmt_link_pkg::byte_t REQ_DATA,
  output logic                      REQ_READY,
  output logic                      DONE,
  output logic                      NACKED,
  output mgmt_link_pkg::byte_t      RD_DATA
);
  import mgmt_link_pkg::*;
  typedef enum {H_IDLE, H_START, H_BIT, H_STOP, H_GAP} hstate_t;
  logic [1:0]  scl_sync_reg;
  logic [1:0]  sda_sync_reg;
  hstate_t     state_reg;
  logic [31:0] sel_cnt_reg;
  logic [15:0] tick_cnt_reg;
  logic        tick;
  logic [1:0]  phase_reg;
  logic [5:0]  bit_reg;
  logic [35:0] frame_reg;
  logic [5:0]  last_bit_reg;
  logic        read_reg;
  logic        scl_oe_reg;
  logic        sda_oe_reg;
  logic [31:0] gap_reg;

  // Synchronise the shared lines.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], LINK.scl};
      sda_sync_reg <= {sda_sync_reg[0], LINK.sda};
    end
  end

  // Select line and its setup timer.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || !SELECT) begin
      sel_cnt_reg <= 32'h0;
    end else if (sel_cnt_reg < 32'(SETUP_CYC)) begin
      sel_cnt_reg <= sel_cnt_reg + 32'h1;
    end
  end
  assign LINK.module_select_n = ~SELECT;

  // Quarter-period tick; holds still while the module stretches SCL.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || tick) begin
      tick_cnt_reg <= 16'h0;
    end else if (!(scl_oe_reg == 1'b0 && scl_sync_reg[1] == 1'b0 && phase_reg != 2'h0)) begin
      tick_cnt_reg <= tick_cnt_reg + 16'h1;
    end
  end
  assign tick = tick_cnt_reg >= (FAST_MODE ? 16'(`SCL_HALF_FAST_CYC / 2) : 16'(`SCL_HALF_DEFAULT_CYC / 2));

  assign REQ_READY = (state_reg == H_IDLE) && (sel_cnt_reg >= 32'(SETUP_CYC)) && SELECT;

  // Initiator sequencer; the frame is three bytes for a write, two for a read and one for a poll, each with its ack slot.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state_reg <= H_IDLE;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      phase_reg <= 2'h0;
      bit_reg <= 6'h0;
      frame_reg <= 36'h0;
      last_bit_reg <= 6'h0;
      read_reg <= 1'b0;
      gap_reg <= 32'h0;
      DONE <= 1'b0;
      NACKED <= 1'b0;
      RD_DATA <= 8'h00;
    end else begin
      DONE <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          if (REQ_VALID && REQ_READY) begin
            read_reg <= REQ_READ;
            frame_reg <= {`DEV_ADDR, REQ_READ, 1'b1, REQ_ADDR, 1'b1, REQ_DATA, 1'b1, 9'h1ff};
            last_bit_reg <= REQ_POLL ? 6'd8 : (REQ_READ ? 6'd17 : 6'd26);
            NACKED <= 1'b0;
            state_reg <= H_START;
          end
        end
        H_START: begin
          if (tick) begin
            sda_oe_reg <= 1'b1;
            phase_reg <= phase_reg + 2'h1;
            if (phase_reg == 2'h1) begin
              scl_oe_reg <= 1'b1;
              phase_reg <= 2'h0;
              bit_reg <= 6'h0;
              state_reg <= H_BIT;
            end
          end
        end
        H_BIT: begin
          if (tick) begin
            phase_reg <= phase_reg + 2'h1;
            case (phase_reg)
              2'h0: sda_oe_reg <= (read_reg && bit_reg > 6'd8) ? 1'b0 : ~frame_reg[35];
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: begin
                if (bit_reg == 6'd8 || bit_reg == 6'd17 || bit_reg == 6'd26) begin
                  if (sda_sync_reg[1] && !(read_reg && bit_reg == 6'd17)) begin
                    NACKED <= 1'b1;
                  end
                end else if (read_reg && bit_reg > 6'd8) begin
                  RD_DATA <= {RD_DATA[6:0], sda_sync_reg[1]};
                end
              end
              default: begin
                scl_oe_reg <= 1'b1;
                frame_reg <= {frame_reg[34:0], 1'b1};
                bit_reg <= bit_reg + 6'h1;
                if (bit_reg == last_bit_reg || NACKED) begin
                  state_reg <= H_STOP;
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            phase_reg <= phase_reg + 2'h1;
            if (phase_reg == 2'h0) sda_oe_reg <= 1'b1;
            if (phase_reg == 2'h1) scl_oe_reg <= 1'b0;
            if (phase_reg == 2'h2) begin
              sda_oe_reg <= 1'b0;
              phase_reg <= 2'h0;
              gap_reg <= 32'(`BUS_FREE_CYC);
              state_reg <= H_GAP;
            end
          end
        end
        H_GAP: begin
          gap_reg <= gap_reg - 32'h1;
          if (gap_reg == 32'h1) begin
            DONE <= 1'b1;
            state_reg <= H_IDLE;
          end
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  assign LINK.scl_h_oe = scl_oe_reg;
  assign LINK.sda_h_oe = sda_oe_reg;
endmodule // mgmt_link_host
`default_nettype wire

// ==== tb/mgmt_serial_flow_timing_checker.sv ====
// Wire-level timing checker for the two-wire management link.
`timescale 1ns/1ps
`default_nettype none
`include "mgmt_link_defs.svh"
module mgmt_serial_flow_timing_checker #(
  parameter int RD_CYC    = 200,
  parameter int NV_CYC    = 4000,
  parameter int SETUP_CYC = 200
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic scl_h_oe,
  input wire logic sda_h_oe,
  input wire logic scl_m_oe,
  input wire logic sda_m_oe,
  input wire logic module_select_n,
  input wire logic scl,
  input wire logic sda
);
  // Two cycles of slack cover the registered select and gap counters.
  localparam int FREE_MIN  = `BUS_FREE_CYC - 2;
  localparam int SETUP_MIN = SETUP_CYC - 2;
  logic [31:0] wr_age;
  logic [31:0] stop_age;
  logic [31:0] sel_cnt;
  logic [31:0] str_cnt;
  logic [4:0]  bits;
  logic        scl_q;
  logic        sda_q;
  logic        start_ev;
  logic        stop_ev;
  logic        ctl_ack;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // --------------------------------------------------
  // Frame decoding
  // --------------------------------------------------
  // Bus conditions seen from the previous sample.
  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev  = scl && scl_q && !sda_q && sda;
  assign ctl_ack  = scl && !scl_q && (bits == 5'h08);
  // Previous line levels.
  always_ff @(posedge SYS_CLK) begin
    scl_q <= scl;
    sda_q <= sda;
  end
  // Rising SCL edges since START; a full write frame has 28 of them, the last in its STOP.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || start_ev) begin
      bits <= 5'h00;
    end else if (scl && !scl_q && bits != 5'h1f) begin
      bits <= bits + 5'h01;
    end
  end
  // Age since any STOP and since the STOP of a full write.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      wr_age   <= 32'h00ff_0000;
      stop_age <= 32'h00ff_0000;
    end else begin
      wr_age   <= (stop_ev && bits >= 5'h14) ? 32'h0 : wr_age + {31'h0, wr_age != '1};
      stop_age <= stop_ev ? 32'h0 : stop_age + {31'h0, stop_age != '1};
    end
  end
  // Select held time and the current stretch length.
  always_ff @(posedge SYS_CLK) begin
    sel_cnt <= (module_select_n || !RST_N) ? 32'h0 : sel_cnt + {31'h0, sel_cnt != '1};
    str_cnt <= (scl_m_oe && RST_N) ? str_cnt + 32'h1 : 32'h0;
  end
  // --------------------------------------------------
  // Assertions
  // --------------------------------------------------
  chk_release_deselect: assert property ($rose(module_select_n) |-> ##[0:2] (!scl_m_oe && !sda_m_oe))
    else $error("module end kept a line after deselect");
  chk_stay_released: assert property (module_select_n [*3] |-> (!scl_m_oe && !sda_m_oe))
    else $error("module end drives while deselected");
  chk_stretch_low: assert property ($rose(scl_m_oe) |-> !$past(scl))
    else $error("stretch began on a high clock");
  chk_stretch_bound: assert property (str_cnt <= RD_CYC)
    else $error("clock stretch too long");
  chk_bus_free_gap: assert property (start_ev |-> stop_age >= FREE_MIN)
    else $error("START too soon after STOP");
  chk_select_setup: assert property (start_ev |-> sel_cnt >= SETUP_MIN)
    else $error("START too soon after select");
  chk_holdoff_ends: assert property (ctl_ack && wr_age >= NV_CYC && !module_select_n |-> !sda)
    else $error("control byte refused after hold-off limit");
  chk_sda_steady: assert property (scl && scl_q && !module_select_n && $past(!module_select_n)
                                   |-> $stable(sda_m_oe))
    else $error("module end moved data while clock high");
  cov_refused: cover property (ctl_ack && sda);
  cov_stretch: cover property (str_cnt == 32'd10);
  cov_abort: cover property ($rose(module_select_n) && scl_m_oe);
endmodule // mgmt_serial_flow_timing_checker
`default_nettype wire

// ==== tb/mgmt_serial_flow_timing_tb_top.sv ====
// Testbench joining host and module ends across the management link.
`timescale 1ns/1ps
`default_nettype none
`include "mgmt_link_defs.svh"
module mgmt_serial_flow_timing_tb_top;
  import mgmt_link_pkg::*;
  // Shortened counts; the non-volatile hold-off outlasts the bus-free gap and a slow control byte.
  localparam int NV  = 6000;
  localparam int VOL = 1600;
  localparam int RD  = 200;
  localparam int SU  = 200;
  logic  SYS_CLK, RST_N, nv_target, rd_valid, fast, sel, req_valid, req_read, req_poll;
  logic  req_ready, done, nacked, busy;
  byte_t rd_byte, req_addr, req_data, host_rd, wr_addr, wr_data, a, d;
  int    fail_count, checks_done, cycles, busy_run, last_busy, kind;
  mgmt_link_if i_link ();
  mgmt_link_dev #(.NV_CYC(NV), .VOL_CYC(VOL), .RD_CYC(RD)) i_mgmt_link_dev (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .LINK(i_link), .NV_TARGET(nv_target), .RD_DATA_VALID(rd_valid), .RD_DATA(rd_byte), .WR_STROBE(),
    .WR_ADDR(wr_addr), .WR_DATA(wr_data), .BUSY(busy));
  mgmt_link_host #(.SETUP_CYC(SU)) i_mgmt_link_host (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .LINK(i_link),
    .FAST_MODE(fast), .SELECT(sel), .REQ_VALID(req_valid), .REQ_READ(req_read), .REQ_POLL(req_poll),
    .REQ_ADDR(req_addr), .REQ_DATA(req_data), .REQ_READY(req_ready), .DONE(done), .NACKED(nacked),
    .RD_DATA(host_rd));
  mgmt_serial_flow_timing_checker #(.RD_CYC(RD), .NV_CYC(NV), .SETUP_CYC(SU)) i_checker (.SYS_CLK(SYS_CLK),
    .RST_N(RST_N), .scl_h_oe(i_link.scl_h_oe), .sda_h_oe(i_link.sda_h_oe), .scl_m_oe(i_link.scl_m_oe),
    .sda_m_oe(i_link.sda_m_oe), .module_select_n(i_link.module_select_n), .scl(i_link.scl), .sda(i_link.sda));
  // Free-running system clock.
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end
  // Hang guard and hold-off length monitor.
  always @(posedge SYS_CLK) begin
    cycles <= cycles + 1;
    busy_run <= busy ? busy_run + 1 : 0;
    if (!busy && busy_run != 0) last_busy <= busy_run;
    if (cycles == 90000) begin
      fail_count++;
      wrap_up();
    end
  end
  function automatic byte_t exp_read(input logic ok, input byte_t v);
    return ok ? v : `DEV_WAIT_BYTE;
  endfunction
  function automatic int holdoff_limit(input logic nv);
    return nv ? NV : VOL;
  endfunction
  task automatic cmp_byte(input byte_t got, input byte_t exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Raises one request once ready and holds it through the taking edge.
  task automatic launch(input logic rd, input logic poll, input byte_t ad, input byte_t dt);
    while (req_ready !== 1'b1) begin
      @(posedge SYS_CLK);
      #2;
    end
    {req_valid, req_read, req_poll, req_addr, req_data} = {1'b1, rd, poll, ad, dt};
    @(posedge SYS_CLK);
    #2;
    req_valid = 1'b0;
  endtask
  // Full transfer: request, then a bounded wait for the completion pulse.
  task automatic xfer(input logic rd, input logic poll, input byte_t ad, input byte_t dt);
    int n;
    n = 0;
    launch(rd, poll, ad, dt);
    while (done !== 1'b1 && n < 20000) begin
      @(posedge SYS_CLK);
      #2;
      n++;
    end
    if (n >= 20000) begin
      fail_count++;
      wrap_up();
    end
  endtask
  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial begin
    void'($urandom(10));
    {RST_N, nv_target, rd_valid, fast, sel, req_valid, req_read, req_poll} = '0;
    {rd_byte, req_addr, req_data} = '0;
    {fail_count, checks_done, cycles, busy_run, last_busy} = '0;
    repeat (5) @(posedge SYS_CLK);
    #2;
    RST_N = 1'b1;
    sel = 1'b1;
    cmp_bit(busy, 1'b0);
    repeat (SU + 5) @(posedge SYS_CLK);
    #2;
    // Random mix of volatile writes, ready reads and stalled reads.
    for (int i = 0; i < 6; i++) begin
      kind = $urandom_range(2, 0);
      fast = 1'($urandom_range(1, 0));
      // Random addresses stay clear of the advertised timing addresses.
      a = {1'b0, 7'($urandom)};
      d = byte_t'($urandom);
      rd_valid = (kind == 1);
      rd_byte = d;
      xfer(kind != 0, 1'b0, a, d);
      cmp_bit(nacked, 1'b0);
      if (kind == 0) begin
        cmp_byte(wr_addr, a);
        cmp_byte(wr_data, d);
        cmp_bit(last_busy <= holdoff_limit(1'b0), 1'b1);
      end else begin
        cmp_byte(host_rd, exp_read(rd_valid, d));
      end
    end
    $display("random traffic done");
    // Advertised select timings read back at their own addresses, at the fast rate.
    fast = 1'b1;
    rd_valid = 1'b0;
    xfer(1'b0, 1'b0, `ADV_SETUP_ADDR, 8'h00);
    xfer(1'b1, 1'b0, 8'h00, 8'h00);
    cmp_byte(host_rd, `ADVERTISED_SETUP);
    xfer(1'b0, 1'b0, `ADV_HOLD_ADDR, 8'h00);
    xfer(1'b1, 1'b0, 8'h00, 8'h00);
    cmp_byte(host_rd, `ADVERTISED_HOLD);
    $display("advertised timing test done");
    // Non-volatile write, refused follow-up, then readiness polling.
    nv_target = 1'b1;
    xfer(1'b0, 1'b0, 8'h7f, 8'h3c);
    cmp_bit(nacked, 1'b0);
    xfer(1'b0, 1'b0, 8'h00, 8'hff);
    cmp_bit(nacked, 1'b1);
    for (int i = 0; i < 6 && nacked !== 1'b0; i++) xfer(1'b0, 1'b1, 8'h00, 8'h00);
    cmp_bit(nacked, 1'b0);
    cmp_bit(last_busy <= holdoff_limit(1'b1), 1'b1);
    cmp_byte(wr_data, 8'h3c);
    $display("hold-off test done");
    // Deselect in the middle of a stretched read.
    rd_valid = 1'b0;
    launch(1'b1, 1'b0, 8'h10, 8'h00);
    for (int n = 0; n < 20000 && i_link.scl_m_oe !== 1'b1; n++) begin
      @(posedge SYS_CLK);
      #2;
    end
    cmp_bit(i_link.scl_m_oe, 1'b1);
    sel = 1'b0;
    repeat (4) @(posedge SYS_CLK);
    #2;
    cmp_bit(i_link.scl_m_oe, 1'b0);
    cmp_bit(i_link.sda_m_oe, 1'b0);
    $display("deselect abort done");
    // Reselect after the host has closed its frame; the module must answer normally.
    for (int n = 0; n < 20000 && done !== 1'b1; n++) begin
      @(posedge SYS_CLK);
      #2;
    end
    sel = 1'b1;
    rd_valid = 1'b1;
    rd_byte = 8'h5a;
    xfer(1'b1, 1'b0, 8'h00, 8'h00);
    cmp_bit(nacked, 1'b0);
    cmp_byte(host_rd, exp_read(rd_valid, rd_byte));
    $display("reselect test done");
    wrap_up();
  end
endmodule // mgmt_serial_flow_timing_tb_top
`default_nettype wire
